// File: dv/label_gen_tb.sv
// self-checking bench for the request label generator
// assumes no virtual map at reset; three builds share one stimulus
`timescale 1ns/100ps
module label_gen_tb;
    import label_gen_pkg::*;
    logic sys_clk_in;
    logic reset_n_in;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic host_flag;
    logic el2_en;
    logic req_valid;
    req_kind_e req_kind;
    logic [1:0] req_level;
    logic req_secure;
    logic req_instr;
    logic pub_in;
    logic [1:0] own_lvl;
    logic own_sec;
    logic lbl_valid;
    logic [PID_W-1:0] pid;
    logic [PMG_W-1:0] monitor_group;
    logic flag;
    logic pub_out;
    logic blocked;
    logic [15:0] taken;
    logic [15:0] illegal;
    int err_total = 0;
    int checks_done = 0;
    int n_lbl = 0;
    logic [31:0] d;
    logic [DATA_W-1:0] rdata_v11;
    logic [DATA_W-1:0] rdata_ro;
    logic [PID_W-1:0] pid_v11;
    logic flag_v11;
    logic valid_v11;

    label_gen #(.VERSION(VER_0_1), .FORCE_WRITABLE(1'b1)) label_gen_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .host_at_hyp_flag_in(host_flag), .el2_enabled_in(el2_en),
        .req_valid_in(req_valid), .req_kind_in(req_kind),
        .req_level_in(req_level), .req_secure_in(req_secure),
        .req_instr_in(req_instr), .address_space_public_in(pub_in),
        .profiler_owner_level_in(own_lvl),
        .profiler_owner_secure_in(own_sec), .lbl_valid_out(lbl_valid),
        .partition_id_out(pid), .monitor_group_out(monitor_group),
        .partition_space_flag_out(flag), .address_space_public_out(pub_out),
        .req_blocked_out(blocked));

    label_gen #(.VERSION(VER_1_1), .FORCE_WRITABLE(1'b0)) label_gen_v11_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata_v11),
        .host_at_hyp_flag_in(host_flag), .el2_enabled_in(el2_en),
        .req_valid_in(req_valid), .req_kind_in(req_kind),
        .req_level_in(req_level), .req_secure_in(req_secure),
        .req_instr_in(req_instr), .address_space_public_in(pub_in),
        .profiler_owner_level_in(own_lvl),
        .profiler_owner_secure_in(own_sec), .lbl_valid_out(valid_v11),
        .partition_id_out(pid_v11), .monitor_group_out(),
        .partition_space_flag_out(flag_v11), .address_space_public_out(),
        .req_blocked_out());

    label_gen #(.VERSION(VER_0_1), .FORCE_WRITABLE(1'b0)) label_gen_ro_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata_ro),
        .host_at_hyp_flag_in(host_flag), .el2_enabled_in(el2_en),
        .req_valid_in(req_valid), .req_kind_in(req_kind),
        .req_level_in(req_level), .req_secure_in(req_secure),
        .req_instr_in(req_instr), .address_space_public_in(pub_in),
        .profiler_owner_level_in(own_lvl),
        .profiler_owner_secure_in(own_sec), .lbl_valid_out(),
        .partition_id_out(), .monitor_group_out(),
        .partition_space_flag_out(), .address_space_public_out(),
        .req_blocked_out());

    label_sink label_sink_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .lbl_valid_in(lbl_valid), .partition_space_flag_in(flag),
        .address_space_public_in(pub_out), .taken_out(taken),
        .illegal_out(illegal));

    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // label word per register slot: distinct id and group in every slot
    function automatic logic [31:0] lab(input int i);
        lab = 32'h00A00C00 + 32'(i) * 32'h00010101;
    endfunction : lab

    task automatic cmp_reg(input string w, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : cmp_reg

    // blocked requests carry no meaningful label, so only strobes compare
    task automatic cmp_lbl(input string w, input logic blk,
                           input logic [31:0] l, input logic fl, pb);
        logic [27:0] e;
        logic [27:0] g;
        e = {~blk, blk, l[23:0], fl, pb};
        g = {lbl_valid, blocked, monitor_group, pid, flag, pub_out};
        if (blk) begin
            e[25:0] = 26'h0000000;
            g[25:0] = 26'h0000000;
        end else begin
            n_lbl++;
        end
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : cmp_lbl

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk_in);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk_in);
        reg_rd <= 1'b0;
        #1;
        cmp_reg($sformatf("reg %h", a), e, reg_rdata);
    endtask : chk_rd

    task automatic req(input req_kind_e k, input logic [1:0] lv,
                       input logic sec, ins, pb,
                       input logic [1:0] ol = 2'h0, input logic os = 1'b0);
        @(posedge sys_clk_in);
        req_valid <= 1'b1;
        req_kind <= k;
        req_level <= lv;
        req_secure <= sec;
        req_instr <= ins;
        pub_in <= pb;
        own_lvl <= ol;
        own_sec <= os;
        @(posedge sys_clk_in);
        req_valid <= 1'b0;
        #1;
    endtask : req

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        reset_n_in = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        host_flag = 1'b0;
        el2_en = 1'b0;
        req_valid = 1'b0;
        req_kind = KIND_NORMAL;
        req_level = 2'h0;
        req_secure = 1'b0;
        req_instr = 1'b0;
        pub_in = 1'b1;
        own_lvl = 2'h0;
        own_sec = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        chk_rd(CTRL_OFS, 32'h00000000);
        chk_rd(8'h08, 32'h00000000);
        reg_write(8'h30, 32'hFFFFFFFF);
        chk_rd(8'h30, 32'h00000000);
        reg_write(CTRL_OFS, 32'h00000002);
        chk_rd(CTRL_OFS, 32'h00000002);
        reg_write(CTRL_OFS, 32'h00000000);
        chk_rd(CTRL_OFS, 32'h00000000);
        cmp_reg("ctrl fixed force", 32'h00000002, rdata_ro);
        cmp_reg("ctrl no force", 32'h00000000, rdata_v11);
        for (int i = 0; i < 8; i++) begin
            reg_write(LABEL_BASE_OFS + 8'(4 * i), lab(i));
        end
        chk_rd(8'h14, lab(5));
        d = lab(2);
        // every level, data and instruction, both security states
        for (int i = 0; i < 8; i++) begin
            req(KIND_NORMAL, 2'(i >> 1), 1'b0, i[0], 1'b1);
            cmp_lbl("ns label", 1'b0, lab(i), 1'b1, 1'b1);
            req(KIND_NORMAL, 2'(i >> 1), 1'b1, i[0], 1'b0);
            cmp_lbl("s label", 1'b0, lab(i), 1'b0, 1'b0);
        end
        @(posedge sys_clk_in);
        host_flag <= 1'b1;
        req(KIND_UNPRIV, 2'h2, 1'b0, 1'b0, 1'b1);
        cmp_lbl("unpriv el2", 1'b0, lab(4), 1'b1, 1'b1);
        req(KIND_UNPRIV, 2'h1, 1'b1, 1'b0, 1'b1);
        cmp_lbl("unpriv el1", 1'b0, lab(2), 1'b0, 1'b1);
        req(KIND_NESTED_SYSREG, 2'h1, 1'b0, 1'b1, 1'b1);
        cmp_lbl("nested", 1'b0, lab(4), 1'b1, 1'b1);
        req(KIND_PROFILER, 2'h0, 1'b0, 1'b0, 1'b1, 2'h2, 1'b1);
        cmp_lbl("profiler", 1'b0, lab(4), 1'b0, 1'b1);
        req(KIND_ADDR_XLATE, 2'h3, 1'b0, 1'b1, 1'b1);
        cmp_lbl("xlate", 1'b0, lab(6), 1'b1, 1'b1);
        reg_write(CTRL_OFS, 32'h00000004);
        req(KIND_NORMAL, 2'h0, 1'b0, 1'b0, 1'b1);
        cmp_lbl("guest lock", 1'b0, lab(2), 1'b1, 1'b1);
        // every select/force combination; non-secure must not care
        for (int c = 0; c < 4; c++) begin
            reg_write(CTRL_OFS, 32'(c));
            req(KIND_NORMAL, 2'h1, 1'b1, 1'b0, 1'b1);
            cmp_lbl("s ctrl", 1'b0, c[0] ? 32'h0 : lab(2), c[1], 1'b1);
            cmp_reg("later ver s", {14'h0, 2'h2, (c[0] ? 16'h0 : d[15:0])},
                    {14'h0, valid_v11, flag_v11, pid_v11});
            req(KIND_NORMAL, 2'h1, 1'b0, 1'b0, 1'b1);
            cmp_lbl("ns ctrl", 1'b0, lab(2), 1'b1, 1'b1);
            req(KIND_NORMAL, 2'h1, 1'b1, 1'b0, 1'b0);
            cmp_lbl("s secure space", c[1], c[0] ? 32'h0 : lab(2), 1'b0,
                    1'b0);
            cmp_reg("later ver space", {14'h0, 2'h2, (c[0] ? 16'h0 : d[15:0])},
                    {14'h0, valid_v11, flag_v11, pid_v11});
        end
        reg_write(CTRL_OFS, 32'h00000000);
        req(KIND_NORMAL, 2'h0, 1'b0, 1'b1, 1'b0);
        cmp_lbl("ns to secure", 1'b1, 32'h0, 1'b1, 1'b0);
        chk_rd(STATUS_OFS, 32'h00000001);
        reg_write(STATUS_OFS, 32'h00000001);
        chk_rd(STATUS_OFS, 32'h00000000);
        // out-of-range virtual id falls back to map entry 0
        reg_write(VPM_BASE_OFS, 32'h00010BEE);
        reg_write(CTRL_OFS, 32'h00000010);
        @(posedge sys_clk_in);
        el2_en <= 1'b1;
        req(KIND_NORMAL, 2'h1, 1'b1, 1'b0, 1'b1);
        cmp_lbl("mapped", 1'b0, {d[31:16], 16'h0BEE}, 1'b0, 1'b1);
        req(KIND_NORMAL, 2'h2, 1'b1, 1'b0, 1'b1);
        cmp_lbl("el2 unmapped", 1'b0, lab(4), 1'b0, 1'b1);
        repeat (2) @(posedge sys_clk_in);
        cmp_reg("sink taken", 32'(n_lbl), {16'h0000, taken});
        cmp_reg("sink illegal", 32'h0, {16'h0000, illegal});
        wrap_up();
    end
endmodule : label_gen_tb

// File: dv/label_sink.sv
// far-side model: a memory-system consumer of labelled requests
// assumes labels are sampled on the rising edge of the one system clock
`timescale 1ns/100ps
module label_sink (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // labelled request
    input wire logic lbl_valid_in,
    input wire logic partition_space_flag_in,
    input wire logic address_space_public_in,
    // statistics
    output logic [15:0] taken_out,
    output logic [15:0] illegal_out
);
    logic [15:0] taken_reg;
    logic [15:0] taken_next;
    logic [15:0] illegal_reg;
    logic [15:0] illegal_next;

    // cross-state (flag 0, public 1) is accepted like any other label
    always_comb begin
        taken_next = taken_reg;
        illegal_next = illegal_reg;
        if (lbl_valid_in) begin
            taken_next = taken_reg + 16'h0001;
            if (partition_space_flag_in && !address_space_public_in) begin
                illegal_next = illegal_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            taken_reg <= 16'h0000;
            illegal_reg <= 16'h0000;
        end else begin
            taken_reg <= taken_next;
            illegal_reg <= illegal_next;
        end
    end

    assign taken_out = taken_reg;
    assign illegal_out = illegal_reg;
endmodule : label_sink

// File: hw/label_gen.sv
// request label generator: partition id, monitor group, space flag
// assumes request inputs come from same-clock logic; outputs one cycle later
//
// Overview of operation
// [R1] unprivileged loads and stores carry the same labels as ordinary ones
// [R2] nested sysreg memory accesses use hypervisor register data fields
// [R3] profiler writes use owning level data labels and its security state
// [R4] address-translate walks use data walk labels of the executing level
// [R5] secure and non-secure levels generate ids identically
// [R6] secure partition ids use flag 0, non-secure ones flag 1
// [R7] from version 1.0 secure state always drives flag 0
// [R8] secure labels from per-level registers, with virtual mapping if enabled
// [R9] never issue flag 1 with secure address space
// [R10] flag 0 with public address space is a legal cross-state request
// [R11] version 1.1: secure default select picks default labels, flag 0
// [R12] version 0.1: force bit sets secure flag, default select picks labels
// [R13] force bit read-one write-ignore, or fully read-write
// [R14] software probes force bit by writing zero and reading back
// [R15] level picks register; guest lock steers EL0 to EL1; EL2/EL3 unmapped
// [R16] data uses data fields, instruction uses instruction fields
// [R17] controls do not affect non-secure requests: flag 1, per-level labels; guest lock and map enables still apply to them
`timescale 1ns/100ps
module label_gen #(
    parameter label_gen_pkg::version_e VERSION = label_gen_pkg::VER_1_1,
    parameter bit FORCE_WRITABLE = 1'b1,
    parameter bit HAS_VIRT = 1'b1
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // register port
    input wire logic [label_gen_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [label_gen_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [label_gen_pkg::DATA_W-1:0] reg_rdata_out,
    // processor state
    input wire logic host_at_hyp_flag_in,
    input wire logic el2_enabled_in,
    // request
    input wire logic req_valid_in,
    input wire label_gen_pkg::req_kind_e req_kind_in,
    input wire logic [1:0] req_level_in,
    input wire logic req_secure_in,
    input wire logic req_instr_in,
    input wire logic address_space_public_in,
    input wire logic [1:0] profiler_owner_level_in,
    input wire logic profiler_owner_secure_in,
    // labelled request
    output logic lbl_valid_out,
    output logic [label_gen_pkg::PID_W-1:0] partition_id_out,
    output logic [label_gen_pkg::PMG_W-1:0] monitor_group_out,
    output logic partition_space_flag_out,
    output logic address_space_public_out,
    output logic req_blocked_out
);
    import label_gen_pkg::*;

    // register state
    logic [PID_W+PMG_W-1:0] label_reg [LABEL_REGS];
    logic [PID_W+PMG_W-1:0] label_next [LABEL_REGS];
    logic [4:0] ctrl_reg, ctrl_next;
    logic blocked_sticky_reg, blocked_sticky_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [DATA_W-1:0] vpm_rdata;
    logic vpm_wr;
    logic force_bit;

    // request state
    logic valid_reg, valid_next;
    logic [PID_W-1:0] pid_reg, pid_next;
    logic [PMG_W-1:0] pmg_reg, pmg_next;
    logic flag_reg, flag_next;
    logic public_reg, public_next;
    logic blocked_reg, blocked_next;

    // selection
    logic [1:0] eff_level;
    logic eff_secure;
    logic eff_instr;
    logic [2:0] sel_idx;
    logic use_virt;
    logic [PID_W+PMG_W-1:0] sel_label;
    logic [PID_W-1:0] phys_id;

    // in version 0.1 without a writable option the force bit reads one and ignores writes; later versions read zero
    assign force_bit = (VERSION != VER_0_1) ? 1'b0 :
                       FORCE_WRITABLE ? ctrl_reg[CTRL_FORCE_OPEN_BIT] :
                       1'b1; // R13
    assign vpm_wr = reg_wr_in && reg_addr_in >= VPM_BASE_OFS &&
                    reg_addr_in <= VPM_END_OFS && reg_addr_in[1:0] == 2'b00;

    always_comb begin
        for (int i = 0; i < LABEL_REGS; i++) begin
            label_next[i] = label_reg[i];
        end
        ctrl_next = ctrl_reg;
        rdata_next = '0;
        // a new block event wins over a clear in the same cycle
        blocked_sticky_next = blocked_sticky_reg;
        if (reg_wr_in && reg_addr_in == STATUS_OFS &&
            reg_wdata_in[STATUS_BLOCKED_BIT]) begin
            blocked_sticky_next = 1'b0;
        end
        if (blocked_reg) begin
            blocked_sticky_next = 1'b1;
        end
        if (reg_wr_in) begin
            if (reg_addr_in <= LABEL_END_OFS && reg_addr_in[1:0] == 2'b00)
            begin
                label_next[reg_addr_in[4:2]] = reg_wdata_in[PID_W+PMG_W-1:0];
            end else if (reg_addr_in == CTRL_OFS) begin
                ctrl_next = reg_wdata_in[4:0];
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in <= LABEL_END_OFS && reg_addr_in[1:0] == 2'b00)
            begin
                rdata_next[PID_W+PMG_W-1:0] = label_reg[reg_addr_in[4:2]];
            end else if (reg_addr_in == CTRL_OFS) begin
                rdata_next[4:0] = ctrl_reg;
                rdata_next[CTRL_FORCE_OPEN_BIT] = force_bit; // R14
            end else if (reg_addr_in == STATUS_OFS) begin
                rdata_next[STATUS_BLOCKED_BIT] = blocked_sticky_reg;
            end else if (reg_addr_in >= VPM_BASE_OFS &&
                         reg_addr_in <= VPM_END_OFS &&
                         reg_addr_in[1:0] == 2'b00) begin
                rdata_next = vpm_rdata;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < LABEL_REGS; i++) begin
            if (!reset_n_in) begin
                label_reg[i] <= LABEL_RESET;
            end else begin
                label_reg[i] <= label_next[i];
            end
        end
        if (!reset_n_in) begin
            ctrl_reg <= CTRL_RESET;
            rdata_reg <= '0;
            blocked_sticky_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            blocked_sticky_reg <= blocked_sticky_next;
        end
    end

    assign reg_rdata_out = rdata_reg;

    vpm_map u_vpm_map (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(vpm_wr),
        .wr_idx_in(reg_addr_in[4:2]),
        .wr_data_in(reg_wdata_in[PID_W:0]),
        .rd_idx_in(reg_addr_in[4:2]),
        .rd_data_out(vpm_rdata),
        .virt_id_in(eff_instr ? sel_label[PID_W-1:0] : sel_label[PID_W-1:0]),
        .phys_id_out(phys_id)
    );

    always_comb begin
        // unprivileged and translate-walk requests keep the issuing level
        eff_level = req_level_in; // R1 R4
        eff_secure = req_secure_in;
        eff_instr = req_instr_in; // R16
        if (req_kind_in == KIND_ADDR_XLATE || req_kind_in == KIND_NESTED_SYSREG)
        begin
            eff_instr = 1'b0; // R4
        end
        if (req_kind_in == KIND_PROFILER) begin
            eff_level = profiler_owner_level_in; // R3
            eff_secure = profiler_owner_secure_in;
            eff_instr = 1'b0;
        end
        // the guest lock redirects EL0 to the EL1 register
        if (eff_level == 2'd0 && ctrl_reg[CTRL_GUEST_LOCK_BIT]) begin
            eff_level = 2'd1; // R15
        end
        if (req_kind_in == KIND_NESTED_SYSREG) begin
            eff_level = 2'd2; // R2
        end
        sel_idx = label_index(eff_level, eff_instr); // R5 R8 R15 R16
        sel_label = label_reg[sel_idx];
        // EL2 and EL3 registers are never mapped
        use_virt = 1'b0;
        if (HAS_VIRT && el2_enabled_in && req_kind_in != KIND_NESTED_SYSREG)
        begin
            if (eff_level == 2'd0) begin
                use_virt = ctrl_reg[CTRL_VPM0_EN_BIT]; // R8 R15
            end else if (eff_level == 2'd1) begin
                use_virt = ctrl_reg[CTRL_VPM1_EN_BIT]; // R8 R15
            end
        end
        pid_next = use_virt ? phys_id : sel_label[PID_W-1:0];
        pmg_next = sel_label[PID_W+PMG_W-1:PMG_LSB];
        flag_next = 1'b1; // R6 R17
        if (eff_secure) begin
            flag_next = 1'b0; // R6 R7
            case (VERSION)
                VER_1_1: begin
                    if (ctrl_reg[CTRL_SEC_DEFAULT_BIT]) begin
                        pid_next = DEFAULT_PARTITION_ID; // R11
                        pmg_next = DEFAULT_MONITOR_GROUP;
                    end
                end
                VER_0_1: begin
                    flag_next = force_bit; // R12
                    if (ctrl_reg[CTRL_SEC_DEFAULT_BIT]) begin
                        pid_next = DEFAULT_PARTITION_ID; // R12
                        pmg_next = DEFAULT_MONITOR_GROUP;
                    end
                end
                default: begin
                    flag_next = 1'b0; // R7
                end
            endcase
        end
        public_next = address_space_public_in; // R10
        // a non-secure label may never reach the secure address space
        blocked_next = req_valid_in && flag_next && !public_next; // R9
        valid_next = req_valid_in && !blocked_next; // R9
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            valid_reg <= 1'b0;
            pid_reg <= DEFAULT_PARTITION_ID;
            pmg_reg <= DEFAULT_MONITOR_GROUP;
            flag_reg <= 1'b0;
            public_reg <= 1'b0;
            blocked_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            pid_reg <= pid_next;
            pmg_reg <= pmg_next;
            flag_reg <= flag_next;
            public_reg <= public_next;
            blocked_reg <= blocked_next;
        end
    end

    assign lbl_valid_out = valid_reg;
    assign partition_id_out = pid_reg;
    assign monitor_group_out = pmg_reg;
    assign partition_space_flag_out = flag_reg;
    assign address_space_public_out = public_reg;
    assign req_blocked_out = blocked_reg;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_ns_req;
        req_valid_in && !req_secure_in && req_kind_in != KIND_PROFILER &&
        address_space_public_in;
    endsequence
    sequence s_sec_req;
        req_valid_in && req_secure_in && req_kind_in != KIND_PROFILER;
    endsequence

    a_no_ns_to_secure: assert property ( // R9
        lbl_valid_out |-> !(partition_space_flag_out &&
                            !address_space_public_out))
        else $error("non-secure label issued to secure space");
    a_ns_flag_one: assert property ( // R17
        s_ns_req |=> lbl_valid_out && partition_space_flag_out)
        else $error("non-secure request lost flag one");
    a_secure_flag_zero: assert property ( // R7
        s_sec_req ##0 (VERSION != VER_0_1) |=> !partition_space_flag_out)
        else $error("secure request flag not zero");
    a_nested_hyp_label: assert property ( // R2
        req_valid_in && req_kind_in == KIND_NESTED_SYSREG |=>
        partition_id_out == $past(label_reg[4][PID_W-1:0]))
        else $error("nested access not from hypervisor data id");
    a_block_pulse: assert property ( // R9
        req_valid_in && !address_space_public_in && !req_secure_in &&
        req_kind_in != KIND_PROFILER |=> req_blocked_out && !lbl_valid_out
        ##1 blocked_sticky_reg)
        else $error("illegal request not blocked and recorded");
    a_sec_default_ids: assert property ( // R11
        s_sec_req ##0 (VERSION != VER_1_0 &&
        ctrl_reg[CTRL_SEC_DEFAULT_BIT]) |=>
        partition_id_out == DEFAULT_PARTITION_ID &&
        monitor_group_out == DEFAULT_MONITOR_GROUP)
        else $error("secure default labels not used");
    a_monitor_instr: assert property ( // R16
        s_ns_req ##0 (req_level_in == 2'd3 && req_instr_in &&
        req_kind_in == KIND_NORMAL) |=>
        partition_id_out == $past(label_reg[7][PID_W-1:0]))
        else $error("instruction fields not used");
    a_unpriv_host: assert property ( // R1
        req_valid_in && req_kind_in == KIND_UNPRIV && host_at_hyp_flag_in &&
        req_level_in == 2'd2 && !req_instr_in && !req_secure_in |=>
        partition_id_out == $past(label_reg[4][PID_W-1:0]))
        else $error("unprivileged access at host level relabelled");
    a_force_reads_one: assert property ( // R13
        reg_rd_in && reg_addr_in == CTRL_OFS && VERSION == VER_0_1 &&
        !FORCE_WRITABLE |=> reg_rdata_out[CTRL_FORCE_OPEN_BIT])
        else $error("force bit not read as one");

endmodule : label_gen

// File: hw/label_gen_pkg.sv
// constants, field layouts and types for the request label generator
// assumes a single 40 MHz clock domain and a plain word-wide register port
package label_gen_pkg;

    localparam int PID_W = 16;
    localparam int PMG_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VPM_ENTRIES = 8;
    localparam int VPM_IDX_W = 3;
    localparam int LABEL_REGS = 8;

    // implementation versions of the partitioning scheme
    typedef enum logic [1:0] {
        VER_0_1,
        VER_1_0,
        VER_1_1
    } version_e;

    // origin of a memory-system request
    typedef enum logic [2:0] {
        KIND_NORMAL,
        KIND_UNPRIV,
        KIND_NESTED_SYSREG,
        KIND_PROFILER,
        KIND_ADDR_XLATE
    } req_kind_e;

    // register byte offsets
    localparam logic [ADDR_W-1:0] LABEL_BASE_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h24;
    localparam logic [ADDR_W-1:0] VPM_BASE_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] LABEL_END_OFS = 8'h1C;
    localparam logic [ADDR_W-1:0] VPM_END_OFS = 8'h5C;

    // label word: partition id low, monitor group above
    localparam int PMG_LSB = 16;
    localparam int VPM_VALID_BIT = 16;

    // control register bits
    localparam int CTRL_SEC_DEFAULT_BIT = 0;
    localparam int CTRL_FORCE_OPEN_BIT = 1;
    localparam int CTRL_GUEST_LOCK_BIT = 2;
    localparam int CTRL_VPM0_EN_BIT = 3;
    localparam int CTRL_VPM1_EN_BIT = 4;
    localparam int STATUS_BLOCKED_BIT = 0;

    // reset values
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [PID_W+PMG_W-1:0] LABEL_RESET = 24'h000000;
    localparam logic [PID_W:0] VPM_RESET = 17'h00000;
    localparam logic [PID_W-1:0] DEFAULT_PARTITION_ID = 16'h0000;
    localparam logic [PMG_W-1:0] DEFAULT_MONITOR_GROUP = 8'h00;
    localparam logic [VPM_IDX_W-1:0] DEFAULT_VIRT_IDX = 3'h0;

    // label register index: level pair per exception level, instr odd
    function automatic logic [2:0] label_index(input logic [1:0] lvl,
                                               input logic instr);
        label_index = {lvl, instr};
    endfunction : label_index

endpackage : label_gen_pkg

// File: hw/vpm_map.sv
// virtual to physical partition id mapping table
// assumes writes and reads come from the label generator register port
`timescale 1ns/100ps
module vpm_map (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // table access
    input wire logic wr_en_in,
    input wire logic [label_gen_pkg::VPM_IDX_W-1:0] wr_idx_in,
    input wire logic [label_gen_pkg::PID_W:0] wr_data_in,
    input wire logic [label_gen_pkg::VPM_IDX_W-1:0] rd_idx_in,
    output logic [label_gen_pkg::DATA_W-1:0] rd_data_out,
    // lookup
    input wire logic [label_gen_pkg::PID_W-1:0] virt_id_in,
    output logic [label_gen_pkg::PID_W-1:0] phys_id_out
);
    import label_gen_pkg::*;

    logic [PID_W:0] entry_reg [VPM_ENTRIES];
    logic [PID_W:0] entry_next [VPM_ENTRIES];
    logic [VPM_IDX_W-1:0] look_idx;

    always_comb begin
        for (int i = 0; i < VPM_ENTRIES; i++) begin
            entry_next[i] = entry_reg[i];
        end
        if (wr_en_in) begin
            entry_next[wr_idx_in] = wr_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < VPM_ENTRIES; i++) begin
            if (!reset_n_in) begin
                entry_reg[i] <= VPM_RESET;
            end else begin
                entry_reg[i] <= entry_next[i];
            end
        end
    end

    always_comb begin
        rd_data_out = '0;
        rd_data_out[PID_W:0] = entry_reg[rd_idx_in];
        // an out-of-range virtual id is replaced by the default entry
        if (virt_id_in < PID_W'(VPM_ENTRIES)) begin
            look_idx = virt_id_in[VPM_IDX_W-1:0];
        end else begin
            look_idx = DEFAULT_VIRT_IDX;
        end
        if (entry_reg[look_idx][VPM_VALID_BIT]) begin
            phys_id_out = entry_reg[look_idx][PID_W-1:0];
        end else if (entry_reg[DEFAULT_VIRT_IDX][VPM_VALID_BIT]) begin
            phys_id_out = entry_reg[DEFAULT_VIRT_IDX][PID_W-1:0];
        end else begin
            phys_id_out = DEFAULT_PARTITION_ID;
        end
    end

endmodule : vpm_map
